// ---- dv/bls_dmem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bls_dmem_model
(
  input  wire logic        clk_i,      // Core clock
  input  wire logic [15:0] dm_addr_i,  // Byte address
  input  wire logic        dm_re_i,    // Read pulse
  input  wire logic        dm_we_i,    // Write pulse
  input  wire logic [7:0]  dm_wdata_i, // Write byte
  output logic      [7:0]  dm_rdata_o  // Read byte
);
  // Small window of data space, upper address bits ignored
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus shows inverted last byte, so stale data never matches
  assign dm_rdata_o = dm_re_i ? mem[dm_addr_i[7:0]] : ~last;
  // Writes land at the edge ending the pulse
  always @(posedge clk_i)
  begin
    if (dm_re_i)
      last <= mem[dm_addr_i[7:0]];
    if (dm_we_i)
      mem[dm_addr_i[7:0]] <= dm_wdata_i;
  end
endmodule
`default_nettype wire

// ---- dv/bls_exec_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module bls_exec_bench;
  import bls_pkg::*;
  logic         clk_i = 1'b0, rst_i = 1'b1;
  logic [7:0]   wb_adr_i = 8'h00, flags_o, dm_wdata_o, dm_rdata_i;
  logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0]   wb_sel_i = 4'hF;
  logic         wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic         instr_valid_i = 1'b0, instr_ready_o, dm_re_o, dm_we_o;
  logic [15:0]  instr_i = 16'h0, instr_next_i = 16'h0, pc_o, dm_addr_o, epc;
  logic [255:0] io_space_i = 256'h0;
  int           fails = 0, check_count = 0, tcount = 0, issued = 0;
  ////////////////////////////////////////////////////////////////////////////
  bls_exec_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .instr_next_i(instr_next_i), .instr_ready_o(instr_ready_o), .pc_o(pc_o), .flags_o(flags_o),
    .io_space_i(io_space_i), .dm_addr_o(dm_addr_o), .dm_re_o(dm_re_o), .dm_we_o(dm_we_o),
    .dm_wdata_o(dm_wdata_o), .dm_rdata_i(dm_rdata_i));
  bls_dmem_model dmem (.clk_i(clk_i), .dm_addr_i(dm_addr_o), .dm_re_i(dm_re_o), .dm_we_i(dm_we_o),
    .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i));
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  // Outputs read right after an edge are the values that edge sampled
  task tick;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Classic cycle held until ack is sampled, then one idle cycle
  // Only the run ceiling ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do
      tick;
    while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    tick;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 32'h0, q);
    chk(q, {24'h0, e});
  endtask
  // Offers one word, counts cycles until ready returns, checks pc
  task automatic issue(input logic [15:0] w, input logic [15:0] nx, input int ec, input logic [15:0] ep);
    int n;
    n = 0;
    {instr_valid_i, instr_i, instr_next_i} <= {1'b1, w, nx};
    do
    begin
      tick;
      n++;
    end while (instr_ready_o !== 1'b1 && n < 20);
    instr_valid_i <= 1'b0;
    issued++;
    n = 1;
    tick;
    while (instr_ready_o !== 1'b1 && n < 20)
    begin
      tick;
      n++;
    end
    chk(n, ec);
    chk(pc_o, ep);
    epc = ep;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rdchk(ADR_CTRL, 8'h00);
    rdchk(ADR_FLAGS, FLAGS_RST);
    rdchk(ADR_PC, 8'h00);
    rdchk(8'h40, 8'h00);
  endtask
  // Every flag index, both forms, condition true and false
  task automatic t_branch;
    logic [7:0] fl;
    logic [6:0] kk;
    logic       c;
    for (int s = 0; s < 8; s++)
      for (int f = 0; f < 2; f++)
        for (int v = 0; v < 2; v++)
        begin
          fl = (s == 4) ? (v ? 8'h04 : 8'h1C) : (v ? 8'h01 << s : ~(8'h01 << s));
          c = (s == 4) ? fl[FLAG_N] ^ fl[FLAG_V] : fl[s];
          kk = f ? 7'h7D : 7'h05;
          wb(1'b1, ADR_FLAGS, {24'h0, fl}, q);
          issue({4'hF, 1'b0, f[0], kk, s[2:0]}, 16'h0, (c ^ f[0]) ? 2 : 1,
            (c ^ f[0]) ? epc + {{9{kk[6]}}, kk} + 16'h0001 : epc + 16'h0001);
          chk(flags_o, fl);
        end
  endtask
  task t_moves;
    issue(16'hE50A, 16'h0, 1, epc + 16'h0001);
    issue(16'hEA15, 16'h0, 1, epc + 16'h0001);
    issue(16'h2E10, 16'h0, 1, epc + 16'h0001);
    issue(16'h0118, 16'h0, 1, epc + 16'h0001);
    rdchk(8'h84, 8'h5A);
    rdchk(8'h88, 8'h5A);
    rdchk(8'h8C, 8'hA5);
  endtask
  // X at top of space, Z at zero: both pointer wraps
  task t_loads;
    wb(1'b1, 8'hE8, 32'hFF, q);
    wb(1'b1, 8'hEC, 32'hFF, q);
    wb(1'b1, 8'hF0, 32'h20, q);
    issue(16'h905D, 16'h0, 2, epc + 16'h0001);
    issue(16'h9062, 16'h0, 2, epc + 16'h0001);
    issue(16'h807B, 16'h0, 2, epc + 16'h0001);
    issue(16'h9080, 16'h0044, 2, epc + 16'h0002);
    rdchk(8'h94, 8'h3C);
    rdchk(8'hE8, 8'h00);
    rdchk(8'hEC, 8'h00);
    rdchk(8'h98, 8'h3C);
    rdchk(8'hF8, 8'hFF);
    rdchk(8'hFC, 8'hFF);
    rdchk(8'h9C, 8'h69);
    rdchk(8'hF0, 8'h20);
    rdchk(8'hA0, 8'h96);
  endtask
  task t_store;
    wb(1'b1, 8'hE8, 32'h30, q);
    issue(16'h921D, 16'h0, 2, epc + 16'h0001);
    chk(dmem.mem[8'h30], 8'h5A);
    rdchk(8'hE8, 8'h31);
  endtask
  // Neighbouring bits opposite, so a slipped index shows
  task t_skip;
    io_space_i <= ~(256'h1 << 29);
    issue(16'h9B1D, 16'h0, 1, epc + 16'h0001);
    io_space_i <= 256'h1 << 29;
    issue(16'h9B1D, 16'h0, 2, epc + 16'h0002);
    issue(16'h9B1D, 16'h9080, 3, epc + 16'h0003);
  endtask
  // Nothing is taken while the enable bit is clear
  task t_gate;
    instr_valid_i <= 1'b1;
    repeat (3) tick;
    chk(instr_ready_o, 1'b0);
    chk(pc_o, 16'h0000);
    instr_valid_i <= 1'b0;
  endtask
  // Unknown word steps once and marks; write one clears; retired count and pc read back
  task t_misc;
    issue(16'h0000, 16'h0, 1, epc + 16'h0001);
    wb(1'b0, ADR_CTRL, 32'h0, q);
    chk(q, 32'h0000_0101);
    wb(1'b1, ADR_CTRL, 32'h0000_0101, q);
    rdchk(ADR_CTRL, 8'h01);
    wb(1'b0, ADR_RETIRED, 32'h0, q);
    chk(q, issued);
    wb(1'b0, ADR_PC, 32'h0, q);
    chk(q, {16'h0000, epc});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Whole run is under two thousand cycles
  always @(posedge clk_i)
  begin
    tcount++;
    if (tcount == 8000)
    begin
      fails++;
      close_out;
    end
  end
  initial
  begin
    dmem.mem[8'hFF] = 8'h3C;
    dmem.mem[8'h23] = 8'h69;
    dmem.mem[8'h44] = 8'h96;
    repeat (10) tick;
    rst_i <= 1'b0;
    tick;
    t_regs;
    t_gate;
    wb(1'b1, ADR_CTRL, 32'h1, q);
    wb(1'b1, ADR_PC, 32'h0100, q);
    epc = 16'h0100;
    t_branch;
    t_moves;
    t_loads;
    t_store;
    t_skip;
    t_misc;
    close_out;
  end
endmodule
`default_nettype wire

// ---- dv/bls_exec_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module bls_exec_props
  import bls_pkg::*;
(
  input wire logic         clk_i,         // Core clock
  input wire logic         rst_i,         // Sync reset
  input wire logic [7:0]   wb_adr_i,      // Bus address
  input wire logic         wb_we_i,       // Bus write
  input wire logic         wb_cyc_i,      // Bus cycle
  input wire logic         wb_stb_i,      // Bus strobe
  input wire logic [31:0]  wb_dat_o,      // Read data
  input wire logic         wb_ack_o,      // Acknowledge
  input wire logic         instr_valid_i, // Word offered
  input wire logic [15:0]  instr_i,       // Current word
  input wire logic [15:0]  instr_next_i,  // Following word
  input wire logic         instr_ready_o, // Executor ready
  input wire logic [15:0]  pc_o,          // Program counter
  input wire logic [7:0]   flags_o,       // Status flags
  input wire logic [255:0] io_space_i,    // I/O bits
  input wire logic         dm_re_o,       // Memory read
  input wire logic         dm_we_o        // Memory write
);
  logic        take, is_br, is_sk, cond, hit, sk_hit, two_w, one_step, fl_wr;
  logic [15:0] br_tgt, sk_tgt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // Decode from the ports only; signed test uses N xor V, not stored S
  assign take     = instr_ready_o && instr_valid_i;
  assign is_br    = (instr_i & M_BRANCH) == V_BR_ONE || (instr_i & M_BRANCH) == V_BR_ZRO;
  assign is_sk    = (instr_i & M_SKIP) == V_SKIP;
  assign cond     = (instr_i[2:0] == 3'h4) ? flags_o[FLAG_N] ^ flags_o[FLAG_V] : flags_o[instr_i[2:0]];
  assign hit      = cond ^ instr_i[10];
  assign sk_hit   = is_sk && io_space_i[instr_i[7:0]];
  assign two_w    = (instr_next_i & 16'hFC0F) == V_ABS_RD || (instr_next_i & M_LJUMP) == V_LJUMP;
  assign br_tgt   = pc_o + {{9{instr_i[9]}}, instr_i[9:3]} + 16'h0001;
  assign sk_tgt   = pc_o + (two_w ? 16'h0003 : 16'h0002);
  assign one_step = (is_br && !hit) || (is_sk && !sk_hit) || (instr_i & M_BCOPY) == V_BCOPY
                    || (instr_i & M_LDCON) == V_LDCON || (instr_i & M_PCOPY) == V_PCOPY;
  assign fl_wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == ADR_FLAGS;
  ////////////////////////////////////////////////////////////////////////////
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not a single pulse");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_flags_hold;
    !fl_wr |=> $stable(flags_o);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags moved by execution");
  property p_rd_walk;
    dm_re_o |-> !instr_ready_o ##1 (instr_ready_o && !dm_re_o);
  endproperty
  a_rd_walk: assert property (p_rd_walk) else $error("load not two cycles");
  property p_wr_walk;
    dm_we_o |-> !instr_ready_o ##1 (instr_ready_o && !dm_we_o);
  endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("store not two cycles");
  property p_br_taken;
    take && is_br && hit |=> pc_o == $past(br_tgt) && !instr_ready_o ##1 instr_ready_o;
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch wrong");
  property p_one_step;
    take && one_step |=> pc_o == $past(pc_o) + 16'h0001 && instr_ready_o;
  endproperty
  a_one_step: assert property (p_one_step) else $error("single cycle step wrong");
  property p_skip;
    take && sk_hit |=> pc_o == $past(sk_tgt) && !instr_ready_o;
  endproperty
  a_skip: assert property (p_skip) else $error("skip target wrong");
  property p_skip_two;
    take && sk_hit && two_w |=> !instr_ready_o [*2] ##1 instr_ready_o;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("long skip not three cycles");
  // Main scenarios reached
  c_branch: cover property (take && is_br && hit);
  c_skip: cover property (take && sk_hit && two_w);
  c_load: cover property (dm_re_o);
  c_store: cover property (dm_we_o);
endmodule
bind bls_exec_top bls_exec_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_next_i(instr_next_i),
  .instr_ready_o(instr_ready_o), .pc_o(pc_o), .flags_o(flags_o), .io_space_i(io_space_i),
  .dm_re_o(dm_re_o), .dm_we_o(dm_we_o));
`default_nettype wire

// ---- verilog/bls_exec_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bls_exec_top
  import bls_pkg::*;
(
  input  wire logic          clk_i,           // Core clock, 40 MHz
  input  wire logic          rst_i,           // Synchronous reset, active high
  input  wire logic [7:0]    wb_adr_i,        // Wishbone byte address
  input  wire logic [31:0]   wb_dat_i,        // Wishbone write data
  input  wire logic [3:0]    wb_sel_i,        // Wishbone byte enables
  input  wire logic          wb_we_i,         // Wishbone write
  input  wire logic          wb_cyc_i,        // Wishbone cycle
  input  wire logic          wb_stb_i,        // Wishbone strobe
  output logic [31:0]        wb_dat_o,        // Wishbone read data
  output logic               wb_ack_o,        // Wishbone acknowledge
  input  wire logic          instr_valid_i,   // Instruction word at pc_o present
  input  wire logic [15:0]   instr_i,         // Instruction word at pc_o
  input  wire logic [15:0]   instr_next_i,    // Word at pc_o plus one
  output logic               instr_ready_o,   // Executor takes an instruction
  output logic [15:0]        pc_o,            // Program counter (words)
  output logic [7:0]         flags_o,         // Status flags
  input  wire logic [255:0]  io_space_i,      // 32 I/O registers, bit 8*A+b
  output logic [15:0]        dm_addr_o,       // Data memory address
  output logic               dm_re_o,         // Data memory read strobe
  output logic               dm_we_o,         // Data memory write strobe
  output logic [7:0]         dm_wdata_o,      // Data memory write byte
  input  wire logic [7:0]    dm_rdata_i       // Read byte, valid in the cycle dm_re_o is high
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    bls_state_t       state;
    logic             ctrl_en;
    logic             unsup;
    logic             rdy;
    logic [15:0]      pc;
    logic [7:0]       flags;
    logic [31:0][7:0] gpr;
    logic [4:0]       to_reg;
    logic [15:0]      retired;
    logic [15:0]      dm_addr;
    logic             dm_re;
    logic             dm_we;
    logic [7:0]       dm_wdata;
    logic             wb_ack;
    logic [31:0]      wb_dat;
  } bls_regs_t;

  bls_regs_t r;
  bls_regs_t n;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Pointer pair as one 16-bit word, high byte in the odd register
  function automatic logic [15:0] ptr_get(input logic [31:0][7:0] g, input logic [4:0] lo);
    logic [4:0] hi;
    hi = lo | 5'h01;
    return {g[hi], g[lo]};
  endfunction

  // Words that carry a second word, for the skip length
  function automatic logic two_word(input logic [15:0] w);
    return ((w & M_PTRMEM) == V_ABS_RD) || ((w & M_PTRMEM) == V_ABS_WR) || ((w & M_LJUMP) == V_LJUMP);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode temporaries

  logic        take;
  logic        wb_hit;
  logic        cond;
  logic        skip;
  logic [2:0]  fsel;
  logic [15:0] w;
  logic [15:0] ptr;
  logic [15:0] ptr_new;
  logic [15:0] addr;
  logic [4:0]  plo;
  logic [4:0]  rd;
  logic [4:0]  rr;
  logic [15:0] br_tgt;
  logic [7:0]  ioa;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    n       = r;
    w       = instr_i;
    take    = (r.state == BLS_IDLE) && r.rdy && instr_valid_i;
    wb_hit  = wb_cyc_i && wb_stb_i && !r.wb_ack;
    fsel    = w[2:0];
    cond    = r.flags[fsel];
    skip    = 1'b0;
    ptr     = 16'h0000;
    ptr_new = 16'h0000;
    addr    = 16'h0000;
    plo     = PTR_X_LO;
    rd      = w[8:4];
    rr      = {w[9], w[3:0]};
    ioa     = w[7:0];
    br_tgt  = r.pc + {{9{w[9]}}, w[9:3]} + 16'h0001;
    n.wb_ack = 1'b0;
    n.wb_dat = 32'h0000_0000;
    n.dm_re  = 1'b0;
    n.dm_we  = 1'b0;

    // Register access; single-cycle answer, unmapped reads return zero
    // Writes land at the ack edge, while the master still holds the request
    n.wb_ack = wb_hit;
    if (wb_hit && !wb_we_i)
    begin
      if (wb_adr_i >= ADR_GPR)
        n.wb_dat = {24'h000000, r.gpr[wb_adr_i[6:2]]};
      else
      begin
        unique case (wb_adr_i)
          ADR_CTRL:    n.wb_dat = {23'h000000, r.unsup, 7'h00, r.ctrl_en};
          ADR_FLAGS:   n.wb_dat = {24'h000000, r.flags};
          ADR_PC:      n.wb_dat = {16'h0000, r.pc};
          ADR_RETIRED: n.wb_dat = {16'h0000, r.retired};
          default:     n.wb_dat = 32'h0000_0000;
        endcase
      end
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && r.wb_ack)
    begin
      if (wb_adr_i >= ADR_GPR)
      begin
        if (wb_sel_i[0])
          n.gpr[wb_adr_i[6:2]] = wb_dat_i[7:0];
      end
      else
      begin
        unique case (wb_adr_i)
          ADR_CTRL:
          begin
            if (wb_sel_i[0])
              n.ctrl_en = wb_dat_i[CTRL_EN_BIT];
            if (wb_sel_i[1] && wb_dat_i[CTRL_UNSUP_BIT])
              n.unsup = 1'b0;               // Write one clears
          end
          ADR_FLAGS:
          begin
            if (wb_sel_i[0])
              n.flags = wb_dat_i[7:0];
          end
          ADR_PC:
          begin
            if (wb_sel_i[0])
              n.pc[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1])
              n.pc[15:8] = wb_dat_i[15:8];
          end
          default: ;
        endcase
      end
    end

    // Instruction sequencer; execution overrides a software write in the same cycle
    unique case (r.state)
      BLS_IDLE:
      begin
        if (take)
        begin
          n.retired = r.retired + 16'h0001;
          n.pc      = r.pc + 16'h0001;
          if ((w & M_SKIP) == V_SKIP)
          begin
            skip = io_space_i[ioa];                                   // [RL1]
            if (skip)
            begin
              n.pc    = two_word(instr_next_i) ? r.pc + 16'h0003 : r.pc + 16'h0002;  // [RL1]
              n.state = two_word(instr_next_i) ? BLS_HOLD2 : BLS_HOLD1;          // [RL19]
            end
          end
          else if (((w & M_BRANCH) == V_BR_ONE) || ((w & M_BRANCH) == V_BR_ZRO))
          begin
            // All named branches are aliases of these two forms with a fixed s
            // Signed branches use N xor V from the flags, not the stored flag S
            if ((w & M_BRANCH) == V_BR_ZRO)
              cond = !r.flags[fsel];                                  // [RL3] [RL4] [RL6] [RL7]
            else
              cond = r.flags[fsel];                                   // [RL2] [RL5] [RL9] [RL10]
            if (fsel == 3'(FLAG_S))
              cond = (r.flags[FLAG_N] ^ r.flags[FLAG_V]) ^ w[10];     // [RL8]
            if (cond)
            begin
              n.pc    = br_tgt;                                       // [RL11] [RL12]
              n.state = BLS_HOLD1;                                    // [RL19]
            end
          end
          else if ((w & M_BCOPY) == V_BCOPY)
            n.gpr[rd] = r.gpr[rr];                                    // [RL13]
          else if ((w & M_PCOPY) == V_PCOPY)
          begin
            n.gpr[{w[7:4], 1'b0}] = r.gpr[{w[3:0], 1'b0}];            // [RL13]
            n.gpr[{w[7:4], 1'b1}] = r.gpr[{w[3:0], 1'b1}];
          end
          else if ((w & M_LDCON) == V_LDCON)
            n.gpr[{1'b1, w[7:4]}] = {w[11:8], w[3:0]};                // [RL13]
          else if (((w & M_PTRMEM) == V_PL_X) || ((w & M_PTRMEM) == V_PL_XI) ||
                   ((w & M_PTRMEM) == V_PL_XD) || ((w & M_PTRMEM) == V_PL_YI) ||
                   ((w & M_PTRMEM) == V_PL_YD) || ((w & M_PTRMEM) == V_PL_ZI) ||
                   ((w & M_PTRMEM) == V_PL_ZD) || ((w & M_PTRMEM) == V_PS_X) ||
                   ((w & M_PTRMEM) == V_PS_XI))
          begin
            if (w[3:2] == 2'b11)
              plo = PTR_X_LO;
            else if (w[3])
              plo = PTR_Y_LO;
            else
              plo = PTR_Z_LO;
            ptr = ptr_get(r.gpr, plo);                                // [RL20]
            if (w[1:0] == 2'b10)
            begin
              ptr_new = ptr - 16'h0001;                               // [RL15] [RL20]
              addr    = ptr_new;
            end
            else
            begin
              ptr_new = (w[1:0] == 2'b01) ? ptr + 16'h0001 : ptr;     // [RL14] [RL18]
              addr    = ptr;
            end
            n.gpr[plo]         = ptr_new[7:0];
            n.gpr[plo | 5'h01] = ptr_new[15:8];
            n.dm_addr          = addr;
            if (w[9])
            begin
              n.dm_we    = 1'b1;                                      // [RL18]
              n.dm_wdata = r.gpr[rd];
              n.state    = BLS_HOLD1;
            end
            else
            begin
              n.dm_re  = 1'b1;                                        // [RL14]
              n.to_reg = rd;
              n.state  = BLS_LOAD;
            end
          end
          else if ((w & M_PTRMEM) == V_ABS_RD)
          begin
            n.pc      = r.pc + 16'h0002;
            n.dm_addr = instr_next_i;                                 // [RL17]
            n.dm_re   = 1'b1;
            n.to_reg  = rd;
            n.state   = BLS_LOAD;
          end
          else if ((w & M_OFFLD) == V_OFFLD)
          begin
            plo       = w[3] ? PTR_Y_LO : PTR_Z_LO;
            n.dm_addr = ptr_get(r.gpr, plo) + {10'h000, w[13], w[11:10], w[2:0]};  // [RL16]
            n.dm_re   = 1'b1;
            n.to_reg  = rd;
            n.state   = BLS_LOAD;
          end
          else
            n.unsup = 1'b1;                 // Left to other units; sticky marker
        end
      end
      BLS_HOLD2:
        n.state = BLS_HOLD1;
      BLS_HOLD1:
        n.state = BLS_IDLE;
      BLS_LOAD:
      begin
        n.gpr[r.to_reg] = dm_rdata_i;                                 // [RL14] [RL17]
        n.state         = BLS_IDLE;
      end
    endcase

    // Ready only when the next cycle can start a fresh instruction
    n.rdy = (n.state == BLS_IDLE) && n.ctrl_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r         <= '0;
      r.state   <= BLS_IDLE;
      r.ctrl_en <= CTRL_EN_RST;
      r.flags   <= FLAGS_RST;
      r.pc      <= PC_RST;
    end
    else
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state

  assign wb_dat_o      = r.wb_dat;
  assign wb_ack_o      = r.wb_ack;
  assign instr_ready_o = r.rdy;
  assign pc_o          = r.pc;
  assign flags_o       = r.flags;
  assign dm_addr_o     = r.dm_addr;
  assign dm_re_o       = r.dm_re;
  assign dm_we_o       = r.dm_we;
  assign dm_wdata_o    = r.dm_wdata;

endmodule
`default_nettype wire

// ---- verilog/bls_pkg.sv ----
// Notes on behaviour
// (RL1) I/O bit one skips next instruction: PC plus 2 or 3, taking 1/2/3 cycles.
// (RL2) Flag-one branch: status bit s set gives PC plus k plus one; 1 or 2 cycles. For s = 4 the code tests N xor V, not the stored S.
// (RL3) Flag-zero branch: status bit s clear gives PC plus k plus one; 1 or 2 cycles. For s = 4 the code tests N xor V, not the stored S.
// (RL4) Equal branch on zero flag one, unequal on zero flag zero; no flag change.
// (RL5) Carry-one and unsigned-lower branches taken on carry one, same relative target.
// (RL6) Carry-zero and unsigned same-or-higher branches taken on carry zero; 1 or 2 cycles.
// (RL7) Negative branch on negative flag one, nonnegative branch on it zero.
// (RL8) Signed ge branch when N xor V is zero, signed lt when it is one.
// (RL9) Half-carry branches on half-carry one or zero, target PC plus k plus one.
// (RL10) User-bit branches on transfer flag one or zero, 1 or 2 cycles.
// (RL11) Overflow branches on overflow flag one or zero; no flag modified.
// (RL12) Irq-enabled branch on global enable one, irq-disabled on it zero.
// (RL13) Byte copy, pair copy and constant load finish in one cycle, flags untouched.
// (RL14) Pointer load via X, Y or Z takes two cycles; post-increment bumps pointer after.
// (RL15) Pre-decrement load subtracts one from pointer first, reads new address, two cycles.
// (RL16) Offset load reads Y or Z plus q, pointer unchanged, two cycles.
// (RL17) Absolute load reads data address k from second word, two cycles.
// (RL18) Pointer store via X writes source byte, two cycles; post-increment bumps X.
// (RL19) Branch: 1 cycle untaken, 2 taken. Skip: 1, 2 one-word, 3 two-word.
// (RL20) X, Y, Z are 16-bit register pairs; increment and decrement wrap at 16 bits.
package bls_pkg;

  // Execution sequencer states
  typedef enum logic [1:0]
  {
    BLS_IDLE  = 2'b00,
    BLS_HOLD1 = 2'b01,
    BLS_HOLD2 = 2'b10,
    BLS_LOAD  = 2'b11
  } bls_state_t;

  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Pointer pair low registers
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  // Opcode masks and match values
  localparam logic [15:0] M_SKIP   = 16'hFF00;
  localparam logic [15:0] V_SKIP   = 16'h9B00;
  localparam logic [15:0] M_BRANCH = 16'hFC00;
  localparam logic [15:0] V_BR_ONE = 16'hF000;
  localparam logic [15:0] V_BR_ZRO = 16'hF400;
  localparam logic [15:0] M_BCOPY  = 16'hFC00;
  localparam logic [15:0] V_BCOPY  = 16'h2C00;
  localparam logic [15:0] M_PCOPY  = 16'hFF00;
  localparam logic [15:0] V_PCOPY  = 16'h0100;
  localparam logic [15:0] M_LDCON  = 16'hF000;
  localparam logic [15:0] V_LDCON  = 16'hE000;
  localparam logic [15:0] M_PTRMEM = 16'hFE0F;
  localparam logic [15:0] V_PL_X   = 16'h900C;
  localparam logic [15:0] V_PL_XI  = 16'h900D;
  localparam logic [15:0] V_PL_XD  = 16'h900E;
  localparam logic [15:0] V_PL_YI  = 16'h9009;
  localparam logic [15:0] V_PL_YD  = 16'h900A;
  localparam logic [15:0] V_PL_ZI  = 16'h9001;
  localparam logic [15:0] V_PL_ZD  = 16'h9002;
  localparam logic [15:0] V_ABS_RD = 16'h9000;
  localparam logic [15:0] V_ABS_WR = 16'h9200;
  localparam logic [15:0] V_PS_X   = 16'h920C;
  localparam logic [15:0] V_PS_XI  = 16'h920D;
  localparam logic [15:0] M_OFFLD  = 16'hD200;
  localparam logic [15:0] V_OFFLD  = 16'h8000;
  localparam logic [15:0] M_LJUMP  = 16'hFE0C;
  localparam logic [15:0] V_LJUMP  = 16'h940C;

  // Register map (byte addresses)
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_FLAGS   = 8'h04;
  localparam logic [7:0] ADR_PC      = 8'h08;
  localparam logic [7:0] ADR_RETIRED = 8'h0C;
  localparam logic [7:0] ADR_GPR     = 8'h80;

  // Control register fields and reset values
  localparam int         CTRL_EN_BIT    = 0;
  localparam int         CTRL_UNSUP_BIT = 8;
  localparam logic       CTRL_EN_RST    = 1'b0;
  localparam logic [7:0] FLAGS_RST      = 8'h00;
  localparam logic [15:0] PC_RST        = 16'h0000;

endpackage
